// ---- pin_control.sv ----
`timescale 1ns/1ps
module pin_control #(
    parameter int NUM_ALT = 4
) (
    input  wire logic                                core_clk,
    input  wire logic                                reset,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [pin_ctrl_pkg::ADDR_W-1:0]     paddr,
    input  wire logic [pin_ctrl_pkg::DATA_W-1:0]     pwdata,
    output logic      [pin_ctrl_pkg::DATA_W-1:0]     prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    input  wire logic                                pad_i,
    output logic                                     pad_o,
    output logic                                     pad_oe_n,
    output logic                                     pull_up_en,
    output logic                                     pull_down_en,
    output pin_ctrl_pkg::drive_t                     drive_sel,
    input  wire logic [NUM_ALT-1:0]                  periph_out,
    input  wire logic [NUM_ALT-1:0]                  periph_oe,
    output logic                                     periph_in
);
    import pin_ctrl_pkg::*;

    localparam int ALT_W = (NUM_ALT > 1) ? $clog2(NUM_ALT) : 1;

    typedef struct packed {
        pin_mode_t          mode;
        pull_t              pull;
        drive_t             drive;
        logic [ALT_W-1:0]   alt;
        logic               buf_v;
        logic               pad_o;
        logic               pad_oe_n;
        logic               pull_up;
        logic               pull_down;
        logic [DATA_W-1:0]  prdata;
        logic               pready;
        logic               pslverr;
    } state_t;

    state_t q;
    state_t d;

    logic                pad_sync;
    logic                setup;
    logic                done;
    logic                wr;
    logic                cfg_wr;
    logic                val_wr;
    logic                mapped;
    logic [DATA_W-1:0]   rd_mux;
    pin_mode_t           wmode;
    pull_t               wpull;
    drive_t              wdrive;
    logic                mode_ok;
    logic                pull_ok;
    logic                drive_ok;
    logic                alt_ok;
    logic                mux_drv;
    logic                mux_oe_n;
    logic                sel_out;
    logic                sel_oe;

    pad_sync2 u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .async_in (pad_i),
        .sync_out (pad_sync)
    );

    assign sel_out = periph_out[q.alt];
    assign sel_oe  = periph_oe[q.alt];

    pad_mux u_mux (
        .mode      (q.mode),
        .buf_v     (q.buf_v),
        .periph_o  (sel_out),
        .periph_oe (sel_oe),
        .drv       (mux_drv),
        .oe_n      (mux_oe_n)
    );

    assign setup  = psel && !penable;
    assign done   = psel && penable && q.pready;
    assign wr     = done && pwrite;
    assign cfg_wr = wr && (paddr == CFG_OFS);
    assign val_wr = wr && (paddr == VALUE_OFS);
    assign mapped = (paddr == CFG_OFS) || (paddr == VALUE_OFS) || (paddr == STATUS_OFS);

    assign wmode    = pin_mode_t'(pwdata[CFG_MODE_LSB +: CFG_MODE_W]);
    assign wpull    = pull_t'(pwdata[CFG_PULL_LSB +: CFG_PULL_W]);
    assign wdrive   = drive_t'(pwdata[CFG_DRIVE_LSB +: CFG_DRIVE_W]);
    assign mode_ok  = wmode inside {MODE_INPUT, MODE_PUSH_PULL, MODE_OPEN_SINK,
                                    MODE_PERIPH, MODE_PERIPH_SINK};
    assign pull_ok  = wpull inside {PULL_NONE, PULL_UP, PULL_DOWN};
    assign drive_ok = wdrive inside {DRIVE_STRENGTH_LOW, drive_strength_medium,
                                     DRIVE_STRENGTH_HIGH};
    assign alt_ok   = 32'(pwdata[CFG_ALT_LSB +: CFG_ALT_W]) < NUM_ALT;

    // Register read data
    always_comb begin
        rd_mux = '0;
        if (paddr == CFG_OFS) begin
            rd_mux[CFG_MODE_LSB +: CFG_MODE_W]   = q.mode;
            rd_mux[CFG_PULL_LSB +: CFG_PULL_W]   = q.pull;
            rd_mux[CFG_DRIVE_LSB +: CFG_DRIVE_W] = q.drive;
            rd_mux[CFG_ALT_LSB +: ALT_W]         = q.alt;
            rd_mux[CFG_VALUE_BIT]                = q.buf_v;
        end else if (paddr == VALUE_OFS) begin
            rd_mux[VAL_LEVEL_BIT] = pad_sync;
        end else if (paddr == STATUS_OFS) begin
            rd_mux[STS_LEVEL_BIT] = pad_sync;
            rd_mux[STS_BUF_BIT]   = q.buf_v;
            rd_mux[STS_DRIVE_BIT] = !q.pad_oe_n;
            rd_mux[STS_PADO_BIT]  = q.pad_o;
        end
    end

    always_comb begin
        d         = q;
        d.pready  = setup;
        d.pslverr = setup && !mapped;
        if (setup) begin
            d.prdata = rd_mux;
        end
        if (cfg_wr) begin
            if (pwdata[CFG_MODE_EN] && mode_ok) begin
                d.mode = wmode;
            end
            if (pwdata[CFG_PULL_EN] && pull_ok) begin
                d.pull = wpull;
            end
            if (pwdata[CFG_DRIVE_EN] && drive_ok) begin
                d.drive = wdrive;
            end
            if (pwdata[CFG_ALT_EN] && alt_ok) begin
                d.alt = pwdata[CFG_ALT_LSB +: ALT_W];
            end
            // initial value only for push-pull and open-sink modes
            if (pwdata[CFG_VALUE_EN]
                && (d.mode == MODE_PUSH_PULL || d.mode == MODE_OPEN_SINK)) begin
                d.buf_v = pwdata[CFG_VALUE_BIT];
            end
        end
        if (val_wr) begin
            d.buf_v = |pwdata;
        end
        d.pad_o     = mux_drv;
        d.pad_oe_n  = mux_oe_n;
        d.pull_up   = (q.pull == PULL_UP);
        d.pull_down = (q.pull == PULL_DOWN);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q          <= '0;
            q.mode     <= MODE_RST;
            q.pull     <= PULL_RST;
            q.drive    <= DRIVE_RST;
            q.buf_v    <= BUF_RST;
            q.pad_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign pad_o        = q.pad_o;
    assign pad_oe_n     = q.pad_oe_n;
    assign pull_up_en   = q.pull_up;
    assign pull_down_en = q.pull_down;
    assign drive_sel    = q.drive;
    assign periph_in    = pad_sync;

    in_hiz_a: assert property (
        @(posedge core_clk) disable iff (reset)
        q.mode == MODE_INPUT |=> q.pad_oe_n)
        else $error("pad driven in input mode");

    pp_drive_a: assert property (
        @(posedge core_clk) disable iff (reset)
        q.mode == MODE_PUSH_PULL |=> !q.pad_oe_n && (q.pad_o == $past(q.buf_v)))
        else $error("push-pull pad not at buffer level");

    sink_low_a: assert property (
        @(posedge core_clk) disable iff (reset)
        (q.mode == MODE_OPEN_SINK) && !q.buf_v |=> !q.pad_oe_n && !q.pad_o)
        else $error("sink-only pad not pulled low");

    sink_rel_a: assert property (
        @(posedge core_clk) disable iff (reset)
        (q.mode == MODE_OPEN_SINK) && q.buf_v |=> q.pad_oe_n)
        else $error("sink-only pad not released");

    in_store_a: assert property (
        @(posedge core_clk) disable iff (reset)
        val_wr && (q.mode == MODE_INPUT) |=> q.pad_oe_n && (q.buf_v == ($past(pwdata) != 0)))
        else $error("input-mode write lost or drove pad");

    true_one_a: assert property (
        @(posedge core_clk) disable iff (reset)
        val_wr |=> q.buf_v == (|$past(pwdata)))
        else $error("buffer not set from written truth value");

    level_read_a: assert property (
        @(posedge core_clk) disable iff (reset)
        setup && (paddr == VALUE_OFS) |=> pready && (prdata[0] == $past(pad_sync)))
        else $error("level read mismatch");

    sync_two_a: assert property (
        @(posedge core_clk) disable iff (reset)
        $past(reset, 2) == 1'b0 |-> pad_sync == $past(pad_i, 2))
        else $error("pad synchroniser latency wrong");

    reset_cfg_a: assert property (
        @(posedge core_clk) disable iff (reset)
        $past(reset) |-> (q.mode == MODE_INPUT) && (q.pull == PULL_NONE) && q.pad_oe_n)
        else $error("reset configuration wrong");

    mode_keep_a: assert property (
        @(posedge core_clk) disable iff (reset)
        cfg_wr && !pwdata[CFG_MODE_EN] && !val_wr |=> q.mode == $past(q.mode))
        else $error("mode changed without being supplied");

    init_skip_a: assert property (
        @(posedge core_clk) disable iff (reset)
        cfg_wr && pwdata[CFG_VALUE_EN]
            && (pwdata[CFG_MODE_EN] ? (wmode == MODE_INPUT) : (q.mode == MODE_INPUT))
            |=> q.buf_v == $past(q.buf_v))
        else $error("initial value applied outside output mode");

    periph_pad_a: assert property (
        @(posedge core_clk) disable iff (reset)
        q.mode == MODE_PERIPH |=> (q.pad_o == $past(sel_out))
            && (q.pad_oe_n == !$past(sel_oe)))
        else $error("peripheral not routed to pad");

    pull_out_a: assert property (
        @(posedge core_clk) disable iff (reset)
        q.pull == PULL_DOWN |=> pull_down_en && !pull_up_en)
        else $error("pull-down not applied");

    pull_up_a: assert property (
        @(posedge core_clk) disable iff (reset)
        q.pull == PULL_UP |=> pull_up_en && !pull_down_en)
        else $error("pull-up not applied");

    psink_pad_a: assert property (
        @(posedge core_clk) disable iff (reset)
        q.mode == MODE_PERIPH_SINK |=> !q.pad_o
            && (q.pad_oe_n == !($past(sel_oe) && !$past(sel_out))))
        else $error("peripheral sink-only pad driven high");

    status_read_a: assert property (
        @(posedge core_clk) disable iff (reset)
        setup && (paddr == STATUS_OFS) |=> pready
            && (prdata[STS_LEVEL_BIT] == $past(pad_sync))
            && (prdata[STS_BUF_BIT] == $past(q.buf_v)))
        else $error("status read mismatch");

    sink_read_a: assert property (
        @(posedge core_clk) disable iff (reset)
        setup && (paddr == VALUE_OFS) && (q.mode == MODE_OPEN_SINK) && q.buf_v
            |=> prdata[VAL_LEVEL_BIT] == $past(pad_sync))
        else $error("released sink-only read not pad level");

    pull_keep_a: assert property (
        @(posedge core_clk) disable iff (reset)
        cfg_wr && !pwdata[CFG_PULL_EN] |=> q.pull == $past(q.pull))
        else $error("pull changed without being supplied");

    drive_bad_a: assert property (
        @(posedge core_clk) disable iff (reset)
        cfg_wr && pwdata[CFG_DRIVE_EN] && (pwdata[CFG_DRIVE_LSB +: CFG_DRIVE_W] == 2'h3)
            |=> q.drive == $past(q.drive))
        else $error("undefined drive code accepted");

endmodule // pin_control

// ---- pin_ctrl_pkg.sv ----
package pin_ctrl_pkg;

    // APB geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] CFG_OFS    = 8'h00;
    localparam logic [ADDR_W-1:0] VALUE_OFS  = 8'h04;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;

    // Configuration register fields
    localparam int CFG_MODE_LSB  = 0;
    localparam int CFG_MODE_W    = 3;
    localparam int CFG_PULL_LSB  = 4;
    localparam int CFG_PULL_W    = 2;
    localparam int CFG_DRIVE_LSB = 8;
    localparam int CFG_DRIVE_W   = 2;
    localparam int CFG_ALT_LSB   = 12;
    localparam int CFG_ALT_W     = 4;
    localparam int CFG_VALUE_BIT = 16;
    localparam int CFG_MODE_EN   = 24;
    localparam int CFG_PULL_EN   = 25;
    localparam int CFG_DRIVE_EN  = 26;
    localparam int CFG_ALT_EN    = 27;
    localparam int CFG_VALUE_EN  = 28;

    // Value and status register fields
    localparam int VAL_LEVEL_BIT  = 0;
    localparam int STS_LEVEL_BIT  = 0;
    localparam int STS_BUF_BIT    = 1;
    localparam int STS_DRIVE_BIT  = 2;
    localparam int STS_PADO_BIT   = 3;

    // Pin modes, Gray coded along input to peripheral sink-only
    typedef enum logic [2:0] {
        MODE_INPUT       = 3'h0,
        MODE_PUSH_PULL   = 3'h1,
        MODE_OPEN_SINK   = 3'h3,
        MODE_PERIPH      = 3'h2,
        MODE_PERIPH_SINK = 3'h6
    } pin_mode_t;

    typedef enum logic [1:0] {
        PULL_NONE = 2'h0,
        PULL_UP   = 2'h1,
        PULL_DOWN = 2'h2
    } pull_t;

    typedef enum logic [1:0] {
        DRIVE_STRENGTH_LOW    = 2'h0,
        drive_strength_medium = 2'h1,
        DRIVE_STRENGTH_HIGH   = 2'h2
    } drive_t;

    // Reset values
    localparam pin_mode_t MODE_RST  = MODE_INPUT;
    localparam pull_t     PULL_RST  = PULL_NONE;
    localparam drive_t    DRIVE_RST = DRIVE_STRENGTH_LOW;
    localparam logic      BUF_RST   = 1'b0;

endpackage

// ---- pad_sync2.sv ----
`timescale 1ns/1ps
module pad_sync2 (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic async_in,
    output logic      sync_out
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    always_comb begin
        d    = q;
        d.s1 = async_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.s2;

endmodule // pad_sync2

// ---- pad_mux.sv ----
`timescale 1ns/1ps
module pad_mux (
    input  wire pin_ctrl_pkg::pin_mode_t mode,
    input  wire logic                    buf_v,
    input  wire logic                    periph_o,
    input  wire logic                    periph_oe,
    output logic                         drv,
    output logic                         oe_n
);
    import pin_ctrl_pkg::*;

    always_comb begin
        drv  = 1'b0;
        oe_n = 1'b1;
        unique case (mode)
            MODE_INPUT: begin
                oe_n = 1'b1;
            end
            MODE_PUSH_PULL: begin
                drv  = buf_v;
                oe_n = 1'b0;
            end
            MODE_OPEN_SINK: begin
                drv  = 1'b0;
                oe_n = buf_v;
            end
            MODE_PERIPH: begin
                drv  = periph_o;
                oe_n = !periph_oe;
            end
            MODE_PERIPH_SINK: begin
                drv  = 1'b0;
                oe_n = !(periph_oe && !periph_o);
            end
            default: begin
                oe_n = 1'b1;
            end
        endcase
    end

endmodule // pad_mux

// ---- pad_far_side.sv ----
`timescale 1ns/1ps
module pad_far_side (
    input  wire logic core_clk,
    input  wire logic pad_o,
    input  wire logic pad_oe_n,
    input  wire logic pull_up_en,
    input  wire logic pull_down_en,
    input  wire logic ext_en,
    input  wire logic ext_val,
    output logic      pad_i
);
    logic float_q = 1'b0;

    // Unpulled floating wire wanders every cycle
    always @(posedge core_clk) begin
        float_q <= !float_q;
    end

    // Device driver first, then far driver, then weak pulls
    always_comb begin
        if (pad_oe_n === 1'b0) begin
            pad_i = pad_o;
        end else if (ext_en) begin
            pad_i = ext_val;
        end else if (pull_up_en === 1'b1) begin
            pad_i = 1'b1;
        end else if (pull_down_en === 1'b1) begin
            pad_i = 1'b0;
        end else begin
            pad_i = float_q;
        end
    end
endmodule // pad_far_side

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import pin_ctrl_pkg::*;

    typedef struct packed {
        logic [31:0] d;
        logic [31:0] m;
        logic        e;
    } note_t;

    localparam logic [31:0] CM = 32'hFFFE_FFFF;

    logic              core_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic              pad_i, pad_o, pad_oe_n, pull_up_en, pull_down_en;
    logic              periph_in, ext_en, ext_val, lv, drv;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, v;
    logic [3:0]        periph_out, periph_oe;
    drive_t            drive_sel;
    note_t             cur;
    note_t             notes[$];
    int                err_total = 0;
    int                checks_done = 0;

    pin_control #(.NUM_ALT(4)) dut (
        .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_i(pad_i), .pad_o(pad_o),
        .pad_oe_n(pad_oe_n), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
        .drive_sel(drive_sel), .periph_out(periph_out), .periph_oe(periph_oe),
        .periph_in(periph_in)
    );

    pad_far_side far (
        .core_clk(core_clk), .pad_o(pad_o), .pad_oe_n(pad_oe_n),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
        .ext_en(ext_en), .ext_val(ext_val), .pad_i(pad_i)
    );

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] x, input logic [31:0] m, input logic e);
        notes.push_back('{x, m, e});
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        xfer(1'b0, a, 32'h0, x, m, 1'b0);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Pad outputs one cycle after the write edge
    task automatic pchk(input logic o, input logic oe_n);
        @(posedge core_clk);
        @(negedge core_clk);
        chk("pad_oe_n", {31'h0, oe_n}, {31'h0, pad_oe_n});
        if (!oe_n) chk("pad_o", {31'h0, o}, {31'h0, pad_o});
    endtask

    function automatic logic [31:0] st(input logic l, b, d, o);
        return {28'h0, o, d, b, l};
    endfunction

    function automatic logic [31:0] cfgw(input logic [2:0] md, input logic [1:0] pl,
        input logic [1:0] dr, input logic [3:0] al, input logic vl, input logic [4:0] en);
        return {3'h0, en, 7'h0, vl, al, 2'h0, dr, 2'h0, pl, 1'h0, md};
    endfunction

    // Result monitor: oldest note against each completed transfer
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1) begin
            cur = notes.pop_front();
            chk("pslverr", {31'h0, cur.e}, {31'h0, pslverr});
            chk("prdata", cur.d & cur.m, prdata & cur.m);
        end
    end

    initial begin
        repeat (4000) @(posedge core_clk);
        err_total++;
        finish_test();
    end

    initial begin
        void'($urandom(13266));
        {reset, psel, penable, pwrite, ext_en, ext_val} = 6'h20;
        paddr = 8'h00;
        pwdata = 32'h0;
        periph_out = 4'h0;
        periph_oe = 4'h0;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        rd(CFG_OFS, 32'h0, CM);
        rd(STATUS_OFS, 32'h0, 32'h6);
        pchk(1'b0, 1'b1);
        xfer(1'b0, 8'h0C, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
        xfer(1'b1, 8'h0C, 32'hA5, 32'h0, 32'h0, 1'b1);
        ext_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'h0 : ($urandom | (32'h1 << (8 * i)));
            lv = 1'($urandom % 2);
            ext_val <= lv;
            wr(VALUE_OFS, v);
            pchk(1'b0, 1'b1);
            idle(2);
            rd(VALUE_OFS, {31'h0, lv}, 32'h1);
            rd(STATUS_OFS, st(lv, v != 0, 1'b0, 1'b0), 32'h7);
        end
        ext_en <= 1'b0;
        wr(CFG_OFS, cfgw(MODE_PUSH_PULL, 2'h0, 2'h0, 4'h0, 1'b0, 5'h01));
        pchk(1'b1, 1'b0);
        for (int b = 0; b < 2; b++) begin
            wr(VALUE_OFS, 32'(b));
            pchk(b[0], 1'b0);
            rd(STATUS_OFS, st(1'b0, b[0], 1'b1, b[0]), 32'hE);
        end
        ext_val <= 1'b0;
        wr(CFG_OFS, cfgw(MODE_OPEN_SINK, 2'h0, 2'h0, 4'h0, 1'b0, 5'h01));
        pchk(1'b0, 1'b1);
        idle(1);
        ext_en <= 1'b1;
        idle(3);
        rd(VALUE_OFS, 32'h0, 32'h1);
        ext_en <= 1'b0;
        wr(CFG_OFS, cfgw(3'h0, PULL_UP, 2'h0, 4'h0, 1'b0, 5'h02));
        idle(3);
        rd(STATUS_OFS, st(1'b1, 1'b1, 1'b0, 1'b0), 32'h7);
        wr(VALUE_OFS, 32'h0);
        pchk(1'b0, 1'b0);
        wr(CFG_OFS, cfgw(MODE_INPUT, 2'h0, 2'h0, 4'h0, 1'b1, 5'h11));
        rd(STATUS_OFS, st(1'b0, 1'b0, 1'b0, 1'b0), 32'h6);
        wr(CFG_OFS, cfgw(MODE_PUSH_PULL, 2'h0, 2'h0, 4'h0, 1'b1, 5'h11));
        rd(STATUS_OFS, st(1'b0, 1'b1, 1'b1, 1'b1), 32'hE);
        rd(CFG_OFS, cfgw(MODE_PUSH_PULL, PULL_UP, 2'h0, 4'h0, 1'b0, 5'h0), CM);
        for (int k = 0; k < 4; k++) begin
            wr(CFG_OFS, cfgw(3'h0, 2'(k), 2'(k), 4'h0, 1'b0, 5'h06));
            @(posedge core_clk);
            @(negedge core_clk);
            chk("pull_up_en", {31'h0, k == 1}, {31'h0, pull_up_en});
            chk("pull_down_en", {31'h0, k >= 2}, {31'h0, pull_down_en});
            chk("drive_sel", {30'h0, 2'((k == 3) ? 2 : k)}, {30'h0, drive_sel});
        end
        for (int s = 0; s < 2; s++) begin
            for (int a = 0; a < 4; a++) begin
                v = $urandom;
                periph_out <= v[3:0];
                periph_oe <= v[7:4];
                drv = v[4 + a] & !(s != 0 && v[a]);
                lv = drv & v[a] & (s == 0);
                wr(CFG_OFS, cfgw((s != 0) ? MODE_PERIPH_SINK : MODE_PERIPH,
                                 2'h0, 2'h0, 4'(a), 1'b0, 5'h09));
                idle(3);
                rd(STATUS_OFS, st(lv, 1'b1, drv, lv), drv ? 32'hF : 32'h7);
                @(negedge core_clk);
                chk("periph_in", {31'h0, lv}, {31'h0, periph_in});
            end
        end
        periph_out <= 4'h0;
        periph_oe <= 4'hF;
        wr(CFG_OFS, cfgw(MODE_INPUT, 2'h0, 2'h0, 4'h0, 1'b0, 5'h01));
        pchk(1'b0, 1'b1);
        wr(CFG_OFS, cfgw(3'h5, 2'h0, 2'h0, 4'h9, 1'b0, 5'h09));
        rd(CFG_OFS, cfgw(MODE_INPUT, PULL_DOWN, 2'h2, 4'h3, 1'b0, 5'h0), CM);
        finish_test();
    end
endmodule // tb_top
